// File: fcpl_defs.svh
// Constants shared by the loader ends: timing counts, serial clock divisors, field positions.
// Assumes a 125 MHz sys_clk; included by the package and modules by bare name.
`ifndef FCPL_DEFS_SVH
`define FCPL_DEFS_SVH
`define FCPL_CLK_MHZ 125
`define FCPL_POR_US 100
`define FCPL_POR_CYC ((`FCPL_POR_US * `FCPL_CLK_MHZ))
`define FCPL_POST_EDGES 3'h2
`define FCPL_INIT_CYC 16'h0040
`define FCPL_OPT_INITDONE 0
// Serial clock divisors of sys_clk (half periods), fastest first; then the host clock's last half-period count
`define FCPL_DIV_100 8'h01
`define FCPL_DIV_50 8'h02
`define FCPL_DIV_25 8'h03
`define FCPL_DIV_12 8'h05
`define FCPL_HOST_HALF 8'h0a
`endif

// File: fcpl_dev.sv
// Device end: configuration control, parallel and serial loading.
// Assumes host pins arrive asynchronously; serial flash is outside this module.
`timescale 1ns/1ps
`include "fcpl_defs.svh"
module fcpl_dev
  import fcpl_pkg::*;
#(
  parameter int POR_CYC = `FCPL_POR_CYC,
  parameter int IMAGE_WORDS = 64
) (
  input wire logic sys_clk,
  input wire logic nrst,
  fcpl_if.dev pins,
  input wire fcpl_mode_t mode,
  input wire fcpl_ckset_t as_clock_set,
  input wire logic as_chain,
  input wire logic init_from_user_clock,
  input wire logic user_supplied_clock,
  input wire logic [3:0] serial_flash_data,
  output logic serial_flash_cmd_out,
  output logic serial_clock_out,
  output logic [31:0] cfg_word,
  output logic cfg_word_valid,
  output logic user_mode,
  output logic data_pins_user
);
  typedef struct packed {
    fcpl_dev_st_t s;
    logic [31:0] cnt;
    logic [31:0] words;
    logic [2:0] post;
    logic [15:0] init;
    logic init_opt;
    logic [2:0] req_sy;
    logic [2:0] clk_sy;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [2:0] uck_sy;
    logic fall_d;
    logic [3:0] as1;
    logic [3:0] as2;
    logic [7:0] sdiv;
    logic sclk;
    logic [31:0] word;
    logic [4:0] nbits;
    logic wvalid;
    logic cmd;
  } fcpl_dev_st_rec_t;
  fcpl_dev_st_rec_t st, next_st;
  logic clk_rise, clk_fall, uck_rise, init_tick, serial, sfall;
  logic [7:0] sdiv_max;
  // Serial divisor; chained loads fall back from the top setting
  function automatic logic [7:0] sel_div(input fcpl_ckset_t c, input logic chain);
    case (c)
      FCPL_CK12: sel_div = `FCPL_DIV_12;
      FCPL_CK25: sel_div = `FCPL_DIV_25;
      FCPL_CK50: sel_div = `FCPL_DIV_50;
      default: sel_div = chain ? `FCPL_DIV_50 : `FCPL_DIV_100;
    endcase
  endfunction : sel_div
  assign serial = (mode == FCPL_AS1) || (mode == FCPL_AS4);
  // Last count of a serial half period
  assign sdiv_max = sel_div(as_clock_set, as_chain) - 8'h01;
  assign sfall = (st.s == DEV_LOAD) && serial && (st.sdiv == sdiv_max) && st.sclk;
  assign clk_rise = st.clk_sy[1] && !st.clk_sy[2];
  assign clk_fall = !st.clk_sy[1] && st.clk_sy[2];
  // User clock edge only after two synchroniser stages
  assign uck_rise = st.uck_sy[1] && !st.uck_sy[2];
  assign init_tick = init_from_user_clock ? uck_rise : 1'b1;
  // Control sequence and data capture
  always_comb begin
    next_st = st;
    next_st.req_sy = {st.req_sy[1:0], pins.config_request_n};
    next_st.clk_sy = {st.clk_sy[1:0], pins.config_clock};
    next_st.d1 = pins.data;
    next_st.d2 = st.d1;
    next_st.uck_sy = {st.uck_sy[1:0], user_supplied_clock};
    next_st.fall_d = sfall;
    next_st.as1 = serial_flash_data;
    next_st.as2 = st.as1;
    next_st.wvalid = 1'b0;
    if (st.s == DEV_LOAD && serial) begin
      next_st.sdiv = (st.sdiv == sdiv_max) ? 8'h00 : st.sdiv + 8'h01;
      if (st.sdiv == sdiv_max) next_st.sclk = !st.sclk;
    end else next_st.sclk = 1'b0;
    case (st.s)
      DEV_POR: begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt == 32'(POR_CYC - 1)) next_st.s = DEV_WAIT;
      end
      DEV_WAIT: if (st.req_sy[2]) begin
        next_st.s = DEV_LOAD;
        next_st.words = 32'h0;
        next_st.nbits = 5'h0;
      end
      DEV_LOAD: begin
        if (sfall) next_st.cmd = st.words[0]; // Launched on the serial falling edge
        if (serial && st.fall_d) begin
          // Flash bits held across the falling edge, seen one stage later
          if (mode == FCPL_AS4) begin
            next_st.word = {st.word[27:0], st.as2};
            next_st.nbits = st.nbits + 5'h4;
          end else begin
            next_st.word = {st.word[30:0], st.as2[0]};
            next_st.nbits = st.nbits + 5'h1;
          end
          if (next_st.nbits == 5'h0) begin
            next_st.wvalid = 1'b1;
            next_st.words = st.words + 32'h1;
          end
        end else if (!serial && clk_rise) begin
          next_st.word = (mode == FCPL_X16) ? {16'h0, st.d2[15:0]} : {24'h0, st.d2[7:0]};
          next_st.wvalid = 1'b1;
          next_st.words = st.words + 32'h1;
        end
        if (next_st.words == 32'(IMAGE_WORDS)) begin
          next_st.s = DEV_POST;
          next_st.post = 3'h0;
        end
        if (next_st.wvalid && st.words == 32'h0) next_st.init_opt = next_st.word[`FCPL_OPT_INITDONE];
      end
      DEV_POST: begin
        if (clk_fall || serial) next_st.post = st.post + 3'h1;
        if (st.post == `FCPL_POST_EDGES) begin
          next_st.s = DEV_INIT;
          next_st.init = 16'h0;
        end
      end
      DEV_INIT: begin
        if (init_tick) next_st.init = st.init + 16'h1;
        if (st.init == `FCPL_INIT_CYC) next_st.s = DEV_USER;
      end
      DEV_USER: ;
      default: next_st.s = DEV_POR;
    endcase
    // Low request restarts from any state but power-on delay
    if (st.s != DEV_POR && !st.req_sy[2]) begin
      next_st.s = DEV_WAIT;
      next_st.init_opt = 1'b0;
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
      st.s <= DEV_POR;
    end else st <= next_st;
  end
  // Pins: status low until delay passes and while request low
  // Status falls with the move to WAIT, so complete is already low beside it
  assign pins.config_status_n_oe = (st.s == DEV_POR) || (st.s == DEV_WAIT && !st.req_sy[2]);
  assign pins.config_complete_oe = (st.s == DEV_POR) || (st.s == DEV_WAIT) || (st.s == DEV_LOAD);
  assign pins.init_done_n_oe = st.init_opt && (st.s == DEV_POST || st.s == DEV_INIT);
  assign serial_flash_cmd_out = st.cmd;
  assign serial_clock_out = st.sclk;
  assign cfg_word = st.word;
  assign cfg_word_valid = st.wvalid;
  assign user_mode = st.s == DEV_USER;
  assign data_pins_user = st.s == DEV_USER;
endmodule : fcpl_dev

// File: fcpl_fifo.sv
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock; synchronous active-low reset.
`timescale 1ns/1ps
module fcpl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fcpl_fifo_st_t;
  fcpl_fifo_st_t st, next_st;
  logic push, pop;
  // Full when pointers differ only in wrap bit
  assign in_ready = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
  assign out_valid = st.wp != st.rp;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rp[AW-1:0]];
  // Pointer update
  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
  end
  // Registers and storage
  always_ff @(posedge sys_clk) begin
    if (!nrst) st <= '0;
    else st <= next_st;
    if (push) mem[st.wp[AW-1:0]] <= in_data;
  end
endmodule : fcpl_fifo

// File: fcpl_host.sv
// Configuration host: drives request, clock and data from a word FIFO.
// Assumes user logic pushes the whole image and raises image_last on its final word.
`timescale 1ns/1ps
`include "fcpl_defs.svh"
module fcpl_host
  import fcpl_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  fcpl_if.host pins,
  input wire logic start,
  input wire logic wide,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [WIDTH-1:0] word_data,
  input wire logic image_last,
  output logic busy,
  output logic done,
  output logic failed
);
  typedef struct packed {
    fcpl_hst_st_t s;
    logic req_n;
    logic clk;
    logic [7:0] div;
    logic [2:0] tail;
    logic [31:0] dat;
    logic last_seen;
    logic have;
    logic done;
    logic failed;
    logic [1:0] st_sy;
    logic [1:0] cd_sy;
  } fcpl_host_st_t;
  fcpl_host_st_t st, next_st;
  logic f_valid, f_ready, f_last;
  logic [WIDTH:0] f_data;
  logic half;
  // Image words buffered ahead of the pins; back-pressure reaches word_ready
  fcpl_fifo #(.WIDTH(WIDTH + 1), .DEPTH(16)) fcpl_fifo_inst (
    .sys_clk(sys_clk), .nrst(nrst), .in_valid(word_valid), .in_ready(word_ready),
    .in_data({image_last, word_data}), .out_valid(f_valid), .out_ready(f_ready),
    .out_data(f_data));
  assign f_last = f_data[WIDTH];
  assign half = st.div == `FCPL_HOST_HALF;
  // Word taken at a fall or with the clock low, so it stands a half period before the rise
  assign f_ready = (st.s == HST_SEND) && half && !st.have && f_valid && !st.last_seen;
  // Sequencing
  always_comb begin
    next_st = st;
    next_st.st_sy = {st.st_sy[0], pins.config_status_n};
    next_st.cd_sy = {st.cd_sy[0], pins.config_complete};
    next_st.div = half ? 8'h00 : st.div + 8'h01;
    case (st.s)
      HST_IDLE: begin
        if (start) begin
          next_st.s = HST_REQ;
          next_st.req_n = 1'b0;
          next_st.done = 1'b0;
          next_st.failed = 1'b0;
          next_st.last_seen = 1'b0;
          next_st.have = 1'b0;
          next_st.tail = 3'h0;
        end
      end
      HST_REQ: if (!st.st_sy[1]) begin
        next_st.req_n = 1'b1;
        next_st.s = HST_WAIT;
      end
      HST_WAIT: if (st.st_sy[1]) next_st.s = HST_SEND;
      HST_SEND: begin
        if (half && st.clk) begin
          next_st.clk = 1'b0; // Falling edge
          if (st.cd_sy[1]) next_st.tail = st.tail + 3'h1;
          if (next_st.tail == `FCPL_POST_EDGES) begin
            next_st.s = HST_TAIL;
            next_st.done = 1'b1;
          end
        end else if (half && (st.have || st.last_seen)) begin
          next_st.clk = 1'b1; // Rise only over a word already standing
          next_st.have = 1'b0;
        end
        if (f_ready) begin
          next_st.dat = wide ? 32'(f_data[WIDTH-1:0]) : {24'h0, f_data[7:0]};
          next_st.last_seen = f_last;
          next_st.have = 1'b1;
        end
        if (!st.st_sy[1]) begin
          next_st.s = HST_IDLE;
          next_st.failed = 1'b1;
        end
      end
      HST_TAIL: begin
        next_st.clk = 1'b0;
        next_st.s = HST_IDLE;
      end
      default: next_st.s = HST_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
      st.s <= HST_IDLE;
      st.req_n <= 1'b1;
    end else st <= next_st;
  end
  assign pins.config_request_n = st.req_n;
  assign pins.config_clock = st.clk; // Low from reset and after a finished load, kept as is after a failure, never floating
  assign pins.data = st.dat;
  assign pins.data_oe = (st.s == HST_SEND);
  assign busy = st.s != HST_IDLE;
  assign done = st.done;
  assign failed = st.failed;
endmodule : fcpl_host

// File: fcpl_if.sv
// Pins between the configuration host and the device.
// Assumes no other drivers; the interface resolves open-drain lines from the enables.
`timescale 1ns/1ps
interface fcpl_if;
  logic config_request_n;
  logic config_status_n_oe; // Device pulls status low while high
  logic config_status_n;
  logic config_complete_oe; // Device pulls complete low while high
  logic config_complete;
  logic config_clock;
  logic [31:0] data;
  logic data_oe;
  logic init_done_n_oe;
  logic init_done;
  // Resolved open-drain levels
  assign config_status_n = !config_status_n_oe;
  assign config_complete = !config_complete_oe;
  assign init_done = !init_done_n_oe;
  modport dev (input config_request_n, output config_status_n_oe, output config_complete_oe,
    input config_status_n, input config_complete, input config_clock, input data,
    output init_done_n_oe);
  modport host (output config_request_n, input config_status_n, input config_complete,
    output config_clock, output data, output data_oe, input init_done);
endinterface : fcpl_if

// File: fcpl_pkg.sv
// Types shared by the loader ends.
// Assumes fcpl_defs.svh is visible on the include path.
`include "fcpl_defs.svh"
package fcpl_pkg;
  typedef enum logic [1:0] {FCPL_X8, FCPL_X16, FCPL_AS1, FCPL_AS4} fcpl_mode_t;
  typedef enum logic [1:0] {FCPL_CK12, FCPL_CK25, FCPL_CK50, FCPL_CK100} fcpl_ckset_t;
  typedef enum {DEV_POR, DEV_WAIT, DEV_LOAD, DEV_POST, DEV_INIT, DEV_USER} fcpl_dev_st_t;
  typedef enum {HST_IDLE, HST_REQ, HST_WAIT, HST_SEND, HST_TAIL} fcpl_hst_st_t;
endpackage : fcpl_pkg

// File: fcpl_props.sv
// Checker on the loader pins between the host and device ends.
// Assumes it sits beside the interface with the bench clock and reset.
`timescale 1ns/1ps
module fcpl_props #(
  parameter int POR_CYC = 20,
  parameter int IMAGE_WORDS = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic config_request_n,
  input wire logic config_status_n,
  input wire logic config_complete,
  input wire logic config_clock,
  input wire logic [31:0] data,
  input wire logic init_done
);
  int por_cnt;
  int words;
  logic opt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Cycles since reset, parallel words since status release, first word option bit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_CYC) begin
      por_cnt <= por_cnt + 1;
    end
    if (!nrst || !config_status_n) begin
      words <= 0;
      opt <= 1'b0;
    end else if ($rose(config_clock)) begin
      words <= words + 1;
      opt <= (words == 0) ? data[0] : opt;
    end
  end
  property p_por_status;
    por_cnt < POR_CYC |-> !config_status_n;
  endproperty
  a_por_status: assert property (p_por_status) else $error("status released early");
  property p_status_complete;
    !config_status_n |-> !config_complete;
  endproperty
  a_status_complete: assert property (p_status_complete) else $error("complete high");
  property p_req_restart;
    $fell(config_request_n) |-> ##[1:8] (!config_status_n && !config_complete);
  endproperty
  a_req_restart: assert property (p_req_restart) else $error("request ignored");
  property p_complete_words;
    $rose(config_complete) && words != 0 |-> words >= IMAGE_WORDS;
  endproperty
  a_complete_words: assert property (p_complete_words) else $error("complete early");
  property p_tail_edges;
    $rose(config_complete) && words != 0 |-> ##[1:40] $fell(config_clock) ##[1:40] $fell(config_clock);
  endproperty
  a_tail_edges: assert property (p_tail_edges) else $error("tail edges missing");
  property p_init_low;
    opt && $rose(config_complete) |-> (!init_done) [*8];
  endproperty
  a_init_low: assert property (p_init_low) else $error("init done not low");
  property p_user_high;
    $rose(init_done) |-> config_complete && config_status_n && config_request_n;
  endproperty
  a_user_high: assert property (p_user_high) else $error("user mode pins not high");
  property p_data_stable;
    $rose(config_clock) |-> $stable(data) [*4];
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved");
  property p_clock_status;
    $rose(config_clock) |-> config_status_n;
  endproperty
  a_clock_status: assert property (p_clock_status) else $error("clock while status low");
endmodule : fcpl_props

// File: test_fpga_config_port_loader.sv
// Bench joining host and device ends; parallel loads, then serial loads after resets.
// Assumes shortened power-on and image counts; inputs change on the falling edge.
`timescale 1ns/1ps
`include "fcpl_defs.svh"
module test_fpga_config_port_loader;
  import fcpl_pkg::*;
  localparam int POR = 20;
  localparam int WORDS = 16;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0, wide = 1'b1, word_valid = 1'b0, image_last = 1'b0;
  logic [15:0] word_data = 16'h0000;
  fcpl_mode_t mode = FCPL_X16;
  fcpl_ckset_t as_clock_set = FCPL_CK12;
  logic as_chain = 1'b0, init_from_user_clock = 1'b0, user_supplied_clock = 1'b0;
  logic [3:0] serial_flash_data = 4'h0;
  logic word_ready, busy, done, failed, serial_clock_out, cfg_word_valid, user_mode;
  logic data_pins_user, prev_sck = 1'b0;
  logic [31:0] cfg_word, fw, msk = 32'h0000ffff;
  logic [31:0] exp_q[$];
  fcpl_ckset_t cks[5] = '{FCPL_CK12, FCPL_CK25, FCPL_CK100, FCPL_CK50, FCPL_CK100};
  int divs[5] = '{`FCPL_DIV_12, `FCPL_DIV_25, `FCPL_DIV_100, `FCPL_DIV_50, `FCPL_DIV_50};
  int fails = 0, n_tests = 0, fbit = 0, gap = 0, half = 0;
  fcpl_if pins_if();
  // Clocks: system and free-running user clock
  always #4 sys_clk = ~sys_clk;
  always #80 user_supplied_clock = ~user_supplied_clock;
  fcpl_host #(.WIDTH(16)) fcpl_host_inst (.sys_clk(sys_clk), .nrst(nrst), .pins(pins_if),
    .start(start), .wide(wide), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .image_last(image_last), .busy(busy), .done(done), .failed(failed));
  fcpl_dev #(.POR_CYC(POR), .IMAGE_WORDS(WORDS)) fcpl_dev_inst (.sys_clk(sys_clk),
    .nrst(nrst), .pins(pins_if), .mode(mode), .as_clock_set(as_clock_set), .as_chain(as_chain),
    .init_from_user_clock(init_from_user_clock), .user_supplied_clock(user_supplied_clock),
    .serial_flash_data(serial_flash_data), .serial_flash_cmd_out(),
    .serial_clock_out(serial_clock_out), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
    .user_mode(user_mode), .data_pins_user(data_pins_user));
  fcpl_props #(.POR_CYC(POR), .IMAGE_WORDS(WORDS)) fcpl_props_inst (.sys_clk(sys_clk),
    .nrst(nrst), .config_request_n(pins_if.config_request_n),
    .config_status_n(pins_if.config_status_n), .config_complete(pins_if.config_complete),
    .config_clock(pins_if.config_clock), .data(pins_if.data), .init_done(pins_if.init_done));
  // Serial image word by index; bit 0 of word 0 enables init done
  function automatic logic [31:0] aw(input int i);
    return {8'ha5 ^ 8'(i), 8'h3c, 8'(i), 8'h81};
  endfunction : aw
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic wait_user(input int bound);
    for (int k = 0; k < bound && user_mode !== 1'b1; k++) @(negedge sys_clk);
    if (user_mode !== 1'b1) begin
      fails++;
      summarize();
    end
  endtask : wait_user
  // Parallel load: fill the FIFO, request, then wait for user mode
  task automatic load(input logic x16, input logic op);
    logic [15:0] w;
    wide = x16;
    msk = x16 ? 32'h0000ffff : 32'h000000ff;
    for (int i = 0; i < WORDS; i++) begin
      w = {8'h7e ^ 8'(i), 7'(i), op && i == 0};
      exp_q.push_back({16'h0000, w});
      word_valid = 1'b1;
      word_data = w;
      image_last = (i == WORDS - 1);
      check(word_ready, 1'b1); // FIFO has room
      @(negedge sys_clk);
    end
    word_valid = 1'b0;
    image_last = 1'b0;
    check(word_ready, 1'b0); // FIFO refuses when full
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    for (int k = 0; k < 50 && pins_if.config_status_n !== 1'b0; k++) @(negedge sys_clk);
    check({pins_if.config_status_n, pins_if.config_complete, user_mode}, 3'h0);
    wait_user(3000);
    check(exp_q.size(), 0);
    check({pins_if.config_request_n, pins_if.config_status_n, pins_if.config_complete,
      pins_if.init_done, data_pins_user, done, failed, word_ready}, 8'hfd);
    $display("parallel load x%0d finished", x16 ? 16 : 8);
  endtask : load
  // Word monitor, serial flash model and serial clock half-period counter
  always @(negedge sys_clk) begin
    if (cfg_word_valid === 1'b1 && exp_q.size() == 0) check(32'h0, 32'h1);
    else if (cfg_word_valid === 1'b1) check(cfg_word & msk, exp_q.pop_front() & msk);
    gap++;
    if (serial_clock_out !== prev_sck) begin
      if (prev_sck === 1'b0) half = gap; // Low phase; a load's end may cut a high one
      gap = 0;
      if (prev_sck === 1'b1) fbit += (mode == FCPL_AS4) ? 4 : 1;
    end
    prev_sck = serial_clock_out;
    fw = aw(fbit / 32);
    serial_flash_data = (mode == FCPL_AS4) ? fw[31 - fbit % 32 -: 4] :
      {fbit[2:0], fw[31 - fbit % 32]};
  end
  // Main sequence
  initial begin
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({pins_if.config_status_n, pins_if.config_complete}, 2'h0);
    repeat (POR + 10) @(negedge sys_clk);
    check(pins_if.config_status_n, 1'b1);
    $display("power-on delay finished");
    load(1'b1, 1'b1);
    load(1'b0, 1'b0);
    for (int t = 0; t < 5; t++) begin
      nrst = 1'b0;
      mode = (t == 2) ? FCPL_AS1 : FCPL_AS4;
      as_clock_set = cks[t];
      as_chain = (t == 4);
      init_from_user_clock = (t == 1);
      msk = 32'hffffffff;
      for (int i = 0; i < WORDS; i++) exp_q.push_back(aw(i));
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      fbit = 0;
      wait_user(6000);
      check(exp_q.size(), 0);
      check(half, divs[t]);
      $display("serial load %0d finished", t);
    end
    summarize();
  end
endmodule : test_fpga_config_port_loader
